// ===== core/olpc_defs.svh
// register map, field positions, reset values and timing figures of the output line block
// assumes byte addressing on a 32-bit classic wishbone bus
`ifndef OLPC_DEFS_SVH
`define OLPC_DEFS_SVH

// ============================================================
// register offsets (byte addresses)
`define ADDR_CMD        8'h00
`define ADDR_SNAP       8'h04
`define ADDR_CFG_BASE   8'h10
`define ADDR_WAIT_BASE  8'h20
`define ADDR_WIDTH_BASE 8'h30
`define ADDR_BASE_MASK  8'hf0

// ============================================================
// config word fields
`define CFG_SRC_LSB     0
`define CFG_EDGE_LSB    4
`define CFG_LEVEL_BIT   8
`define CFG_HOLD_BIT    9
`define CFG_USED_MASK   32'h0000_0337

// output_source_select codes
`define SRC_SW_LEVEL    3'h0
`define SRC_SW_PULSE    3'h1
`define SRC_EVT_BASE    3'h2

// pulse_edge_select codes
`define EDGE_UP         2'h0
`define EDGE_DOWN       2'h1
`define EDGE_EITHER     2'h2

// ============================================================
// reset values
`define CFG_RST         32'h0000_0000
`define WAIT_RST        16'h0000
`define WIDTH_RST       16'h0001

// ============================================================
// timing
`define NS_PER_US       1000
`define CLK_PERIOD_NS   10

`endif

// ===== core/olpc_pkg.sv
// types shared by the output line block and its pulse timer
// assumes nothing beyond a systemverilog compiler
package olpc_pkg;

  // ============================================================
  // timing carrier
  localparam int TIME_W = 16;

  typedef struct packed {
    logic [TIME_W-1:0] width_us;
    logic [TIME_W-1:0] wait_us;
  } pulse_timing_t;

  // ============================================================
  // per-output configuration
  typedef struct packed {
    logic       sw_hold_mode;
    logic       static_level;
    logic [1:0] pulse_edge_select;
    logic [2:0] output_source_select;
  } out_cfg_t;

  typedef enum logic [1:0] {
    PT_IDLE,
    PT_WAIT,
    PT_HIGH
  } pt_state_t;

endpackage

// ===== core/pulse_timer.sv
// one-shot pulse generator: waits pulse_wait_us, then stays high pulse_width_us
// assumes trig_i is a one-cycle pulse; timing_i held steady while busy
`timescale 1ns/10ps
`include "olpc_defs.svh"
module pulse_timer import olpc_pkg::*; #(
  parameter int CYC_PER_US = 100
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // trigger and timing
  input  wire logic          trig_i,
  input  wire pulse_timing_t timing_i,
  // result
  output logic               pulse_o,
  output logic               busy_o
);

  localparam int CW = (CYC_PER_US > 1) ? $clog2(CYC_PER_US) : 1;
  localparam logic [CW-1:0] CYC_LAST = CW'(CYC_PER_US - 1);

  pt_state_t         st_q, st_d;
  logic [CW-1:0]     cyc_q, cyc_d;
  logic [TIME_W-1:0] us_q, us_d, limit, us_inc;

  // ============================================================
  // sequencing
  always_comb begin
    st_d   = st_q;
    cyc_d  = cyc_q;
    us_d   = us_q;
    limit  = (st_q == PT_WAIT) ? timing_i.wait_us : timing_i.width_us;
    us_inc = TIME_W'(us_q + 1'b1);
    case (st_q)
      PT_IDLE: begin
        if (trig_i) begin
          cyc_d = '0;
          us_d  = '0;
          if (timing_i.wait_us != '0) begin
            st_d = PT_WAIT;
          end else if (timing_i.width_us != '0) begin
            st_d = PT_HIGH;
          end
        end
      end
      PT_WAIT, PT_HIGH: begin
        // microsecond tick derived from the system clock
        if (cyc_q == CYC_LAST) begin
          cyc_d = '0;
          us_d  = us_inc;
          if (us_inc == limit) begin
            us_d = '0;
            if (st_q == PT_WAIT && timing_i.width_us != '0) begin
              st_d = PT_HIGH;
            end else begin
              st_d = PT_IDLE;
            end
          end
        end else begin
          cyc_d = CW'(cyc_q + 1'b1);
        end
      end
      default: st_d = PT_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q  <= PT_IDLE;
      cyc_q <= '0;
      us_q  <= '0;
    end else begin
      st_q  <= st_d;
      cyc_q <= cyc_d;
      us_q  <= us_d;
    end
  end

  assign pulse_o = (st_q == PT_HIGH);
  assign busy_o  = (st_q != PT_IDLE);

  // ============================================================
  // checks
  int dwell_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || st_d != st_q) begin
      dwell_q <= 0;
    end else begin
      dwell_q <= dwell_q + 1;
    end
  end

  AST_WAIT_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == PT_WAIT && st_d != PT_WAIT) |-> dwell_q + 1 == int'(timing_i.wait_us) * CYC_PER_US)
    else $error("pulse delay length wrong");

  AST_WIDTH_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == PT_HIGH && st_d != PT_HIGH) |-> dwell_q + 1 == int'(timing_i.width_us) * CYC_PER_US)
    else $error("pulse width length wrong");

endmodule

// ===== core/output_line_pulse_control.sv
// output line controller: per-output source, edge, delay, width, static and latched levels
// assumes a classic wishbone master on clk_i and event inputs synchronous to clk_i
//
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "olpc_defs.svh"
module output_line_pulse_control import olpc_pkg::*; #(
  parameter int N_OUT = 4,
  parameter int N_IN  = 2,
  parameter int N_EVT = 4
) (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic [31:0]             wb_dat_o,
  output logic                    wb_ack_o,
  // source events and input lines
  input  wire logic [N_EVT-1:0]   event_i,
  input  wire logic [N_IN-1:0]    in_line_i,
  // output circuits, one closes the circuit
  output logic [N_OUT-1:0]        out_closed_o
);

  localparam int CYC_PER_US = `NS_PER_US / `CLK_PERIOD_NS;

  // ============================================================
  // helpers
  function automatic logic [31:0] merge_sel(input logic [31:0] old_w, input logic [31:0] new_w,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic out_cfg_t cfg_of(input logic [31:0] w);
    out_cfg_t c;
    c.output_source_select = w[`CFG_SRC_LSB +: 3];
    c.pulse_edge_select    = w[`CFG_EDGE_LSB +: 2];
    c.static_level         = w[`CFG_LEVEL_BIT];
    c.sw_hold_mode         = w[`CFG_HOLD_BIT];
    return c;
  endfunction

  function automatic logic is_event_src(input logic [2:0] src);
    return (src >= `SRC_EVT_BASE) && (32'(src - `SRC_EVT_BASE) < N_EVT);
  endfunction

  function automatic logic pick_event(input logic [2:0] src, input logic [N_EVT-1:0] ev);
    logic r;
    r = 1'b0;
    for (int e = 0; e < N_EVT; e++) begin
      if (32'(src - `SRC_EVT_BASE) == e) begin
        r = ev[e];
      end
    end
    return r & is_event_src(src);
  endfunction

  // ============================================================
  // register state
  logic [31:0]         cfg_q   [N_OUT];
  logic [31:0]         cfg_d   [N_OUT];
  logic [TIME_W-1:0]   wait_q  [N_OUT];
  logic [TIME_W-1:0]   wait_d  [N_OUT];
  logic [TIME_W-1:0]   width_q [N_OUT];
  logic [TIME_W-1:0]   width_d [N_OUT];
  logic                ack_q, ack_d;
  logic [31:0]         dat_q, dat_d;
  logic                wr_go;
  logic [7:0]          base;
  logic [1:0]          idx;
  logic                idx_ok;
  logic                cmd_wr;
  logic [N_OUT-1:0]    cmd_bits;
  logic [N_IN+N_OUT-1:0] snapshot;

  assign wr_go  = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
  assign base   = wb_adr_i & `ADDR_BASE_MASK;
  assign idx    = wb_adr_i[3:2];
  assign idx_ok = 32'(idx) < N_OUT;
  assign cmd_wr = wr_go && wb_adr_i == `ADDR_CMD && wb_sel_i[0];

  // all set bits issue their commands together
  assign cmd_bits = cmd_wr ? wb_dat_i[N_OUT-1:0] : '0;

  // line states, first line lowest
  assign snapshot = {out_closed_o, in_line_i};

  // ============================================================
  // bus slave: ack one cycle after the request, writes land on the ack edge
  always_comb begin
    ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
    dat_d = dat_q;
    if (ack_d && !wb_we_i) begin
      dat_d = '0;
      if (wb_adr_i == `ADDR_SNAP) begin
        dat_d = 32'(snapshot);
      end else if (idx_ok && base == `ADDR_CFG_BASE) begin
        dat_d = cfg_q[idx] & `CFG_USED_MASK;
      end else if (idx_ok && base == `ADDR_WAIT_BASE) begin
        dat_d = 32'(wait_q[idx]);
      end else if (idx_ok && base == `ADDR_WIDTH_BASE) begin
        dat_d = 32'(width_q[idx]);
      end
    end
    for (int k = 0; k < N_OUT; k++) begin
      cfg_d[k]   = cfg_q[k];
      wait_d[k]  = wait_q[k];
      width_d[k] = width_q[k];
      if (wr_go && 32'(idx) == k) begin
        if (base == `ADDR_CFG_BASE) begin
          cfg_d[k] = merge_sel(cfg_q[k], wb_dat_i, wb_sel_i) & `CFG_USED_MASK;
        end else if (base == `ADDR_WAIT_BASE) begin
          wait_d[k] = TIME_W'(merge_sel(32'(wait_q[k]), wb_dat_i, wb_sel_i));
        end else if (base == `ADDR_WIDTH_BASE) begin
          width_d[k] = TIME_W'(merge_sel(32'(width_q[k]), wb_dat_i, wb_sel_i));
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= '0;
      for (int k = 0; k < N_OUT; k++) begin
        cfg_q[k]   <= `CFG_RST;
        wait_q[k]  <= `WAIT_RST;
        width_q[k] <= `WIDTH_RST;
      end
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
      for (int k = 0; k < N_OUT; k++) begin
        cfg_q[k]   <= cfg_d[k];
        wait_q[k]  <= wait_d[k];
        width_q[k] <= width_d[k];
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ============================================================
  // trigger selection and line drive
  out_cfg_t         cfg     [N_OUT];
  logic [N_OUT-1:0] src_lvl;
  logic [N_OUT-1:0] src_prev_q, src_prev_d;
  logic [N_OUT-1:0] rise, fall, trig, cmd_hit;
  logic [N_OUT-1:0] held_q, held_d;
  logic [N_OUT-1:0] line_q, line_d;
  logic [N_OUT-1:0] pulse;
  logic [N_OUT-1:0] tmr_busy;

  always_comb begin
    for (int k = 0; k < N_OUT; k++) begin
      cfg[k]        = cfg_of(cfg_q[k]);
      src_lvl[k]    = pick_event(cfg[k].output_source_select, event_i);
      src_prev_d[k] = src_lvl[k];
      rise[k]       = src_lvl[k] & ~src_prev_q[k];
      fall[k]       = ~src_lvl[k] & src_prev_q[k];
      cmd_hit[k]    = 1'b0;
      held_d[k]     = held_q[k];
      trig[k]       = 1'b0;
      case (cfg[k].pulse_edge_select)
        `EDGE_UP:   trig[k] = rise[k];
        `EDGE_DOWN: trig[k] = fall[k];
        default:    trig[k] = rise[k] | fall[k];
      endcase
      if (cfg[k].output_source_select == `SRC_SW_PULSE) begin
        cmd_hit[k] = cmd_bits[k];
        trig[k]    = cmd_bits[k];
      end else if (cfg[k].output_source_select == `SRC_SW_LEVEL && cfg[k].sw_hold_mode) begin
        cmd_hit[k] = cmd_bits[k];
        if (cmd_bits[k]) begin
          held_d[k] = cfg[k].static_level;
        end
      end
      // level sources depend on software choosing them first
      if (cfg[k].output_source_select == `SRC_SW_LEVEL) begin
        line_d[k] = cfg[k].sw_hold_mode ? held_d[k] : cfg[k].static_level;
      end else begin
        line_d[k] = pulse[k];
      end
      // outside latched mode the hold follows the pin, so entering latched
      // mode leaves the pin where it is until the next command
      if (!(cfg[k].output_source_select == `SRC_SW_LEVEL && cfg[k].sw_hold_mode)) begin
        held_d[k] = line_d[k];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_prev_q <= '0;
      held_q     <= '0;
      line_q     <= '0;
    end else begin
      src_prev_q <= src_prev_d;
      held_q     <= held_d;
      line_q     <= line_d;
    end
  end

  // one is a closed circuit, zero open
  assign out_closed_o = line_q;

  // ============================================================
  // pulse timers
  genvar g;
  generate
    for (g = 0; g < N_OUT; g++) begin : g_tmr
      pulse_timing_t tm;
      assign tm.wait_us  = wait_q[g];
      assign tm.width_us = width_q[g];
      pulse_timer #(
        .CYC_PER_US (CYC_PER_US)
      ) u_tmr (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .trig_i   (trig[g]),
        .timing_i (tm),
        .pulse_o  (pulse[g]),
        .busy_o   (tmr_busy[g])
      );
    end
  endgenerate

  // ============================================================
  // checks on output 0, on command bit one reaching output 1, and on the bus slave
  logic evt0;
  assign evt0 = is_event_src(cfg[0].output_source_select);

  AST_EDGE_UP: assert property (@(posedge clk_i) disable iff (rst_i)
    (evt0 && cfg[0].pulse_edge_select == `EDGE_UP) |-> (trig[0] == (src_lvl[0] && !$past(src_lvl[0]))))
    else $error("rising edge trigger wrong");

  AST_EDGE_DOWN: assert property (@(posedge clk_i) disable iff (rst_i)
    (evt0 && cfg[0].pulse_edge_select == `EDGE_DOWN) |-> (trig[0] == (!src_lvl[0] && $past(src_lvl[0]))))
    else $error("falling edge trigger wrong");

  AST_EDGE_EITHER: assert property (@(posedge clk_i) disable iff (rst_i)
    (evt0 && cfg[0].pulse_edge_select == `EDGE_EITHER) |-> (trig[0] == (src_lvl[0] != $past(src_lvl[0]))))
    else $error("either edge trigger wrong");

  AST_STATIC: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg[0].output_source_select == `SRC_SW_LEVEL && !cfg[0].sw_hold_mode)
      |=> out_closed_o[0] == $past(cfg[0].static_level))
    else $error("static level not driven");

  AST_LATCH_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg[0].output_source_select == `SRC_SW_LEVEL && cfg[0].sw_hold_mode && !cmd_bits[0])
      |=> $stable(out_closed_o[0]))
    else $error("latched line moved without command");

  AST_CMD_APPLY: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_wr && wb_dat_i[0] && cfg[0].output_source_select == `SRC_SW_LEVEL && cfg[0].sw_hold_mode)
      |=> out_closed_o[0] == $past(cfg[0].static_level))
    else $error("command did not apply latched level");

  AST_CMD_IGNORE: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg[0].output_source_select != `SRC_SW_PULSE
      && !(cfg[0].output_source_select == `SRC_SW_LEVEL && cfg[0].sw_hold_mode)) |-> !cmd_hit[0])
    else $error("command reached a non-software output");

  AST_SW_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_wr && wb_dat_i[0] && cfg[0].output_source_select == `SRC_SW_PULSE && !pulse[0]
      && wait_q[0] == '0 && width_q[0] != '0) |=> ##1 out_closed_o[0])
    else $error("software command gave no pulse");

  AST_CMD_MAP: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_wr && wb_dat_i[1] && cfg[1].output_source_select == `SRC_SW_LEVEL && cfg[1].sw_hold_mode)
      |=> out_closed_o[1] == $past(cfg[1].static_level))
    else $error("command bit one missed the second output");

  AST_SNAP: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_d && !wb_we_i && wb_adr_i == `ADDR_SNAP) |=> wb_dat_o == 32'($past(snapshot)))
    else $error("snapshot read wrong");

  AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  AST_ACK_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");

  AST_RD_UNMAPPED: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_d && !wb_we_i && base > `ADDR_WIDTH_BASE) |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  AST_DAT_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    !(ack_d && !wb_we_i) |=> $stable(wb_dat_o))
    else $error("read data moved without a read");

  AST_START_NOW: assert property (@(posedge clk_i) disable iff (rst_i)
    (trig[0] && !tmr_busy[0] && wait_q[0] == '0 && width_q[0] != '0) |=> pulse[0])
    else $error("zero delay pulse did not start");

  AST_IDLE_OPEN: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg[0].output_source_select != `SRC_SW_LEVEL && !tmr_busy[0]) |=> !out_closed_o[0])
    else $error("line closed while its timer idle");

  COV_EVT_PULSE: cover property (@(posedge clk_i) disable iff (rst_i)
    evt0 && trig[0] ##[1:300] out_closed_o[0]);
  COV_SW_PULSE: cover property (@(posedge clk_i) disable iff (rst_i)
    cmd_wr && cfg[0].output_source_select == `SRC_SW_PULSE && cmd_bits[0]);
  COV_LATCH: cover property (@(posedge clk_i) disable iff (rst_i)
    cmd_hit[0] && cfg[0].output_source_select == `SRC_SW_LEVEL);
  COV_SNAP: cover property (@(posedge clk_i) disable iff (rst_i)
    ack_d && !wb_we_i && wb_adr_i == `ADDR_SNAP);
  COV_EDGE_DOWN: cover property (@(posedge clk_i) disable iff (rst_i)
    evt0 && trig[0] && cfg[0].pulse_edge_select == `EDGE_DOWN);

endmodule

// ===== sim/line_equipment.sv
// model of the equipment wired to the line circuits: counts closures, times them, drives input lines
// assumes out_closed_i is registered on clk_i and in_level_i comes from the bench
`timescale 1ns/10ps
module line_equipment #(
  parameter int N_OUT = 4,
  parameter int N_IN  = 2
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // circuits and input lines
  input  wire logic [N_OUT-1:0]      out_closed_i,
  input  wire logic [N_IN-1:0]       in_level_i,
  output logic [N_IN-1:0]            in_line_o,
  // observations
  output logic [N_OUT-1:0][15:0]     closes_o,
  output logic [N_OUT-1:0][15:0]     width_o
);
  logic [N_OUT-1:0][15:0] run_q;
  logic [N_OUT-1:0]       prev_q;

  assign in_line_o = in_level_i;

  // ============================================================
  // a one closes the circuit: count closures, time each closed span in cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q    <= '0;
      prev_q   <= '0;
      closes_o <= '0;
      width_o  <= '0;
    end else begin
      for (int k = 0; k < N_OUT; k++) begin
        if (out_closed_i[k]) begin
          run_q[k] <= run_q[k] + 16'h0001;
        end
        if (out_closed_i[k] && !prev_q[k]) begin
          closes_o[k] <= closes_o[k] + 16'h0001;
        end
        if (!out_closed_i[k] && prev_q[k]) begin
          width_o[k] <= run_q[k];
          run_q[k]   <= 16'h0000;
        end
      end
      prev_q <= out_closed_i;
    end
  end
endmodule

// ===== sim/output_line_pulse_control_tb.sv
// self-checking bench of the output line block, registers over classic wishbone
// assumes the line equipment model on the far side and default parameters
`timescale 1ns/10ps
`include "olpc_defs.svh"
module output_line_pulse_control_tb import olpc_pkg::*;;
  logic              clk_i;
  logic              rst_i;
  logic              wb_cyc_i;
  logic              wb_stb_i;
  logic              wb_we_i;
  logic [7:0]        wb_adr_i;
  logic [3:0]        wb_sel_i;
  logic [31:0]       wb_dat_i;
  logic [31:0]       wb_dat_o;
  logic              wb_ack_o;
  logic [3:0]        event_i;
  logic [1:0]        in_level;
  logic [1:0]        in_line;
  logic [3:0]        out_closed;
  logic [3:0][15:0]  closes;
  logic [3:0][15:0]  width;
  int                fails;
  int                n_tests;

  output_line_pulse_control #(.N_OUT(4), .N_IN(2), .N_EVT(4)) output_line_pulse_control_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .event_i(event_i), .in_line_i(in_line), .out_closed_o(out_closed));

  line_equipment #(.N_OUT(4), .N_IN(2)) line_equipment_i (
    .clk_i(clk_i), .rst_i(rst_i), .out_closed_i(out_closed), .in_level_i(in_level),
    .in_line_o(in_line), .closes_o(closes), .width_o(width));

  always #5 clk_i = ~clk_i;

  // ============================================================
  // reporting
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // ============================================================
  // classic single wishbone cycle, held until ack
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      fails++;
      end_sim();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, adr, wd, d);
  endtask

  task automatic settle();
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  // ============================================================
  // scenarios
  task automatic t_reset();
    logic [31:0] d;
    bus(1'b0, `ADDR_CFG_BASE, 32'h0, d);
    check("cfg0 reset", d, `CFG_RST);
    bus(1'b0, `ADDR_WAIT_BASE, 32'h0, d);
    check("wait0 reset", d, {16'h0000, `WAIT_RST});
    bus(1'b0, `ADDR_WIDTH_BASE, 32'h0, d);
    check("width0 reset", d, {16'h0000, `WIDTH_RST});
    bus(1'b0, 8'h40, 32'h0, d);
    check("unmapped read", d, 32'h0000_0000);
    wr(`ADDR_CFG_BASE, 32'hffff_ffff);
    bus(1'b0, `ADDR_CFG_BASE, 32'h0, d);
    check("cfg0 used bits", d, `CFG_USED_MASK);
    wr(`ADDR_CMD, 32'h0000_0001);
    settle();
    check("no source ignores command", {28'h0, out_closed}, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_static();
    logic [31:0] d;
    @(posedge clk_i);
    in_level <= 2'b10;
    wr(`ADDR_CFG_BASE, 32'h0000_0100); // software level source selected with the level
    settle();
    check("static level closes", {28'h0, out_closed}, 32'h0000_0001);
    bus(1'b0, `ADDR_SNAP, 32'h0, d);
    check("snapshot", d, {26'h0, 4'b0001, 2'b10});
    wr(`ADDR_CFG_BASE, 32'h0000_0000);
    settle();
    check("inactive opens", {28'h0, out_closed}, 32'h0000_0000);
    $display("test static done");
  endtask

  task automatic t_latch();
    wr(`ADDR_CFG_BASE + 8'h04, 32'h0000_0300);
    wr(`ADDR_CFG_BASE, 32'h0000_0300);
    settle();
    check("latched waits", {28'h0, out_closed}, 32'h0);
    wr(`ADDR_CMD, 32'h0000_0002);
    settle();
    check("latched applied", {28'h0, out_closed}, 32'h0000_0002);
    wr(`ADDR_CMD, 32'h0000_0001);
    settle();
    check("bit zero first output", {28'h0, out_closed}, 32'h0000_0003);
    $display("test latch done");
  endtask

  task automatic t_pulse();
    int          n;
    logic [15:0] c;
    logic [15:0] c0;
    wr(`ADDR_CFG_BASE, {29'h0, `SRC_SW_PULSE});
    wr(`ADDR_CFG_BASE + 8'h08, {29'h0, `SRC_SW_PULSE});
    wr(`ADDR_WAIT_BASE + 8'h08, 32'h0000_0001);
    wr(`ADDR_WIDTH_BASE + 8'h08, 32'h0000_0001);
    wr(`ADDR_CFG_BASE + 8'h04, 32'h0000_0200);
    c = closes[2];
    c0 = closes[0];
    wr(`ADDR_CMD, 32'h0000_000f);
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (out_closed[2] !== 1'b1 && n < 300);
    check("pulse delay", 32'(n), 32'd101);
    check("latched drop same write", {31'h0, out_closed[1]}, 32'h0);
    check("others ignore", {31'h0, out_closed[3]}, 32'h0);
    repeat (110) @(posedge clk_i);
    #1;
    check("pulse width", {16'h0, width[2]}, 32'd100);
    check("one sw pulse", {16'h0, closes[2] - c}, 32'h1);
    check("zero delay pulse width", {16'h0, width[0]}, 32'd100);
    check("zero delay pulse count", {16'h0, closes[0] - c0}, 32'h1);
    $display("test pulse done");
  endtask

  task automatic t_edge();
    logic [15:0] c;
    for (int m = 0; m < 4; m++) begin
      wr(`ADDR_CFG_BASE, {26'h0, 2'(m), 4'h2});
      c = closes[0];
      @(posedge clk_i);
      event_i <= 4'h1;
      repeat (300) @(posedge clk_i);
      check("rise response", {16'h0, closes[0] - c}, (m == 1) ? 32'h0 : 32'h1);
      event_i <= 4'h0;
      repeat (300) @(posedge clk_i);
      #1;
      check("edge pulses", {16'h0, closes[0] - c}, (m < 2) ? 32'h1 : 32'h2);
    end
    $display("test edge done");
  endtask

  // ============================================================
  // main sequence
  initial begin
    clk_i    = 1'b0;
    rst_i    = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    event_i  = 4'h0;
    in_level = 2'b00;
    fails    = 0;
    n_tests  = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_static();
    t_latch();
    t_pulse();
    t_edge();
    end_sim();
  end
endmodule
